//--- rtl/eqr_defs.svh
// Offsets, field positions, reset values and codes of the equalizer/retimer register page
`ifndef EQR_DEFS_SVH
`define EQR_DEFS_SVH

// Register offsets inside the page
`define EQR_OFS_PAGE_RESET 8'h00
`define EQR_OFS_LOS_STATUS 8'h01
`define EQR_OFS_RECOVERY_STATUS 8'h02
`define EQR_OFS_MANUAL_BOOST 8'h03
`define EQR_OFS_SPARE_FIRST 8'h04
`define EQR_OFS_SPARE_LAST 8'h08
`define EQR_OFS_ROUTING_OVERRIDE 8'h09
`define EQR_OFS_FIRST_MUX_CTRL 8'h1C
`define EQR_OFS_SECOND_MUX_CTRL 8'h1E
`define EQR_OFS_EQ_MODE_CTRL 8'h2D
`define EQR_OFS_BOOST_READBACK 8'h52

// Field positions
`define EQR_PAGE_RESET_BIT 2
`define EQR_LOS_BIT 1
`define EQR_MANUAL_EN_BIT 3
`define EQR_OVERRIDE_BIT 5
`define EQR_COMMON_SEL_HI 3
`define EQR_COMMON_SEL_LO 2
`define EQR_OWN_SEL_HI 7
`define EQR_OWN_SEL_LO 5

// Reset values
`define EQR_RST_PAGE_RESET 8'h00
`define EQR_RST_LOS_STATUS 8'h03
`define EQR_RST_RECOVERY_STATUS 8'h41
`define EQR_RST_MANUAL_BOOST 8'h80
`define EQR_RST_SPARE 8'h00
`define EQR_RST_ROUTING_OVERRIDE 8'h00
`define EQR_RST_FIRST_MUX_CTRL 8'h00
`define EQR_RST_SECOND_MUX_CTRL 8'h00
`define EQR_RST_EQ_MODE_CTRL 8'h00
`define EQR_RST_READ_DATA 8'h00

// Page-select code that opens this page
`define EQR_PAGE_CODE 3'h4
`define EQR_SPARE_COUNT 5

`endif

//--- rtl/eqr_pkg.sv
// Types shared by the equalizer/retimer register page
package eqr_pkg;
  typedef logic [7:0] eqr_byte_t;
  typedef logic [2:0] eqr_page_t;
  typedef logic [2:0] eqr_mux_sel_t;
endpackage

//--- rtl/eqr_sync.sv
// Two-flop synchroniser with a constant reset value
`timescale 1ns/100ps
module eqr_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  input wire clk,
  input wire rst,
  input wire [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);
  logic [WIDTH-1:0] stage1_reg;

  // First stage feeds only the second stage
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage1_reg <= RESET_VAL;
      syncOut <= RESET_VAL;
    end else begin
      stage1_reg <= asyncIn;
      syncOut <= stage1_reg;
    end
  end
endmodule

//--- rtl/eqr_page_regs.sv
// Register page for trace equalizer boost, recovery status and output routing
// Functional notes
// - Writing one to bit 2 at 0x00 resets the page; bit self-clears.
// - Bit 1 at 0x01 reads one on trace input signal loss, zero otherwise.
// - Read-only 8-bit recovery status word at 0x02, default 0x41.
// - Boost register 0x03 holds four 2-bit stage controls, default 0x80.
// - Manual stage boosts drive the equalizer only while 0x2D bit 3 is one.
// - Boost in use by the equalizer reads back at 0x52.
// - With override clear, 0x1C bits 3:2 route both outputs together.
// - With override set, outputs route from 0x1C and 0x1E bits 7:5.
`timescale 1ns/100ps
`include "eqr_defs.svh"
module eqr_page_regs (
  input wire clk,
  input wire rst,
  input wire eqr_pkg::eqr_page_t pageSelect,
  input wire regWrite,
  input wire regRead,
  input wire eqr_pkg::eqr_byte_t regAddr,
  input wire eqr_pkg::eqr_byte_t regWdata,
  output eqr_pkg::eqr_byte_t regRdata,
  output logic regRdValid,
  input wire traceInputSignalLost,
  input wire eqr_pkg::eqr_byte_t recoveryStatusIn,
  input wire eqr_pkg::eqr_byte_t adaptiveBoost,
  output eqr_pkg::eqr_byte_t appliedBoost,
  output eqr_pkg::eqr_mux_sel_t firstOutputMuxSel,
  output eqr_pkg::eqr_mux_sel_t secondOutputMuxSel
);
  import eqr_pkg::*;

  eqr_byte_t pageResetCtrl_reg;
  logic pageResetPulse_reg;
  eqr_byte_t manualStageBoost_reg;
  eqr_byte_t spare_reg [`EQR_SPARE_COUNT];
  eqr_byte_t routingOverride_reg;
  eqr_byte_t firstMuxCtrl_reg;
  eqr_byte_t secondMuxCtrl_reg;
  eqr_byte_t eqModeCtrl_reg;
  logic losSync;
  eqr_byte_t recoveryStatusSync;
  eqr_byte_t statusPrev_reg;
  eqr_byte_t statusStable_reg;
  logic pageOpen;
  logic wrHit;
  logic rdHit;
  eqr_byte_t readValue;

  // Pin-side status crosses two flops; the wide status word is then filtered for agreement
  eqr_sync #(.WIDTH(1), .RESET_VAL(1'b1)) losSyncInst (
    .clk(clk),
    .rst(rst),
    .asyncIn(traceInputSignalLost),
    .syncOut(losSync)
  );

  eqr_sync #(.WIDTH(8), .RESET_VAL(`EQR_RST_RECOVERY_STATUS)) statusSyncInst (
    .clk(clk),
    .rst(rst),
    .asyncIn(recoveryStatusIn),
    .syncOut(recoveryStatusSync)
  );

  // Status word taken only when two samples agree, so bits caught mid-change never read as a mix
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      statusPrev_reg <= `EQR_RST_RECOVERY_STATUS;
      statusStable_reg <= `EQR_RST_RECOVERY_STATUS;
    end else begin
      statusPrev_reg <= recoveryStatusSync;
      if (recoveryStatusSync == statusPrev_reg) begin
        statusStable_reg <= recoveryStatusSync;
      end
    end
  end

  // Access gating; writes during the page reset cycle are dropped
  assign pageOpen = (pageSelect == `EQR_PAGE_CODE);
  assign wrHit = regWrite && pageOpen && !pageResetPulse_reg;
  assign rdHit = regRead && pageOpen;

  // True when the address falls in the spare block
  function automatic logic isSpare(input eqr_byte_t addr);
    isSpare = (addr >= `EQR_OFS_SPARE_FIRST) && (addr <= `EQR_OFS_SPARE_LAST);
  endfunction

  // Index of a spare location from its address
  function automatic logic [2:0] spareIndex(input eqr_byte_t addr);
    eqr_byte_t diff;
    diff = addr - `EQR_OFS_SPARE_FIRST;
    spareIndex = diff[2:0];
  endfunction

  // Self-clearing page reset strobe, armed by a write of bit 2
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pageResetPulse_reg <= 1'b0;
    end else begin
      pageResetPulse_reg <= wrHit && (regAddr == `EQR_OFS_PAGE_RESET) && regWdata[`EQR_PAGE_RESET_BIT];
    end
  end

  // Writable registers; the page reset strobe returns all of them to defaults
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pageResetCtrl_reg <= `EQR_RST_PAGE_RESET;
      manualStageBoost_reg <= `EQR_RST_MANUAL_BOOST;
      routingOverride_reg <= `EQR_RST_ROUTING_OVERRIDE;
      firstMuxCtrl_reg <= `EQR_RST_FIRST_MUX_CTRL;
      secondMuxCtrl_reg <= `EQR_RST_SECOND_MUX_CTRL;
      eqModeCtrl_reg <= `EQR_RST_EQ_MODE_CTRL;
      for (int i = 0; i < `EQR_SPARE_COUNT; i++) begin
        spare_reg[i] <= `EQR_RST_SPARE;
      end
    end else if (pageResetPulse_reg) begin
      pageResetCtrl_reg <= `EQR_RST_PAGE_RESET;
      manualStageBoost_reg <= `EQR_RST_MANUAL_BOOST;
      routingOverride_reg <= `EQR_RST_ROUTING_OVERRIDE;
      firstMuxCtrl_reg <= `EQR_RST_FIRST_MUX_CTRL;
      secondMuxCtrl_reg <= `EQR_RST_SECOND_MUX_CTRL;
      eqModeCtrl_reg <= `EQR_RST_EQ_MODE_CTRL;
      for (int i = 0; i < `EQR_SPARE_COUNT; i++) begin
        spare_reg[i] <= `EQR_RST_SPARE;
      end
    end else if (wrHit) begin
      // Reset bit is stored so it reads back one until the strobe clears it
      if (regAddr == `EQR_OFS_PAGE_RESET) begin
        pageResetCtrl_reg <= regWdata;
      end
      if (regAddr == `EQR_OFS_MANUAL_BOOST) begin
        manualStageBoost_reg <= regWdata;
      end
      if (isSpare(regAddr)) begin
        spare_reg[spareIndex(regAddr)] <= regWdata;
      end
      if (regAddr == `EQR_OFS_ROUTING_OVERRIDE) begin
        routingOverride_reg <= regWdata;
      end
      if (regAddr == `EQR_OFS_FIRST_MUX_CTRL) begin
        firstMuxCtrl_reg <= regWdata;
      end
      if (regAddr == `EQR_OFS_SECOND_MUX_CTRL) begin
        secondMuxCtrl_reg <= regWdata;
      end
      if (regAddr == `EQR_OFS_EQ_MODE_CTRL) begin
        eqModeCtrl_reg <= regWdata;
      end
    end
  end

  // Read decode; unmapped holes read zero
  always_comb begin
    readValue = `EQR_RST_READ_DATA;
    if (isSpare(regAddr)) begin
      readValue = spare_reg[spareIndex(regAddr)];
    end else begin
      case (regAddr)
        `EQR_OFS_PAGE_RESET: readValue = pageResetCtrl_reg;
        `EQR_OFS_LOS_STATUS: readValue = {6'h00, losSync, 1'b1};
        `EQR_OFS_RECOVERY_STATUS: readValue = statusStable_reg;
        `EQR_OFS_MANUAL_BOOST: readValue = manualStageBoost_reg;
        `EQR_OFS_ROUTING_OVERRIDE: readValue = routingOverride_reg;
        `EQR_OFS_FIRST_MUX_CTRL: readValue = firstMuxCtrl_reg;
        `EQR_OFS_SECOND_MUX_CTRL: readValue = secondMuxCtrl_reg;
        `EQR_OFS_EQ_MODE_CTRL: readValue = eqModeCtrl_reg;
        `EQR_OFS_BOOST_READBACK: readValue = appliedBoost;
        default: readValue = `EQR_RST_READ_DATA;
      endcase
    end
  end

  // Read answer one cycle after the strobe; closed page answers zero so software never hangs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      regRdata <= `EQR_RST_READ_DATA;
      regRdValid <= 1'b0;
    end else begin
      regRdValid <= regRead;
      regRdata <= rdHit ? readValue : `EQR_RST_READ_DATA;
    end
  end

  // Boost in use: manual stages only while manual mode is enabled
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      appliedBoost <= `EQR_RST_READ_DATA;
    end else begin
      appliedBoost <= eqModeCtrl_reg[`EQR_MANUAL_EN_BIT] ? manualStageBoost_reg : adaptiveBoost;
    end
  end

  // Output routing: common 2-bit select or per-output 3-bit selects
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      firstOutputMuxSel <= 3'h0;
      secondOutputMuxSel <= 3'h0;
    end else if (routingOverride_reg[`EQR_OVERRIDE_BIT]) begin
      firstOutputMuxSel <= firstMuxCtrl_reg[`EQR_OWN_SEL_HI:`EQR_OWN_SEL_LO];
      secondOutputMuxSel <= secondMuxCtrl_reg[`EQR_OWN_SEL_HI:`EQR_OWN_SEL_LO];
    end else begin
      firstOutputMuxSel <= {1'b0, firstMuxCtrl_reg[`EQR_COMMON_SEL_HI:`EQR_COMMON_SEL_LO]};
      secondOutputMuxSel <= {1'b0, firstMuxCtrl_reg[`EQR_COMMON_SEL_HI:`EQR_COMMON_SEL_LO]};
    end
  end

  // Checks next to the logic
  AST_PAGE_RESET_RESTORES: assert property (@(posedge clk) disable iff (rst)
    (wrHit && regAddr == `EQR_OFS_PAGE_RESET && regWdata[`EQR_PAGE_RESET_BIT]) |-> ##2
    (manualStageBoost_reg == `EQR_RST_MANUAL_BOOST && routingOverride_reg == `EQR_RST_ROUTING_OVERRIDE
     && !pageResetCtrl_reg[`EQR_PAGE_RESET_BIT]))
    else $error("page reset did not restore defaults");

  AST_RESET_SELF_CLEARS: assert property (@(posedge clk) disable iff (rst)
    pageResetPulse_reg |=> !pageResetPulse_reg)
    else $error("page reset strobe lasted more than one cycle");

  AST_LOS_READ: assert property (@(posedge clk) disable iff (rst)
    (rdHit && regAddr == `EQR_OFS_LOS_STATUS) |=> (regRdata[`EQR_LOS_BIT] == $past(losSync) && regRdValid))
    else $error("loss status read mismatch");

  AST_STATUS_READ: assert property (@(posedge clk) disable iff (rst)
    (rdHit && regAddr == `EQR_OFS_RECOVERY_STATUS) |=> regRdata == $past(statusStable_reg))
    else $error("recovery status read mismatch");

  AST_MANUAL_APPLIED: assert property (@(posedge clk) disable iff (rst)
    eqModeCtrl_reg[`EQR_MANUAL_EN_BIT] |=> appliedBoost == $past(manualStageBoost_reg))
    else $error("manual boost not applied");

  AST_ADAPTIVE_APPLIED: assert property (@(posedge clk) disable iff (rst)
    !eqModeCtrl_reg[`EQR_MANUAL_EN_BIT] |=> appliedBoost == $past(adaptiveBoost))
    else $error("adaptive boost not passed while manual mode off");

  AST_BOOST_READBACK: assert property (@(posedge clk) disable iff (rst)
    (rdHit && regAddr == `EQR_OFS_BOOST_READBACK) |=> regRdata == $past(appliedBoost))
    else $error("boost readback mismatch");

  AST_COMMON_ROUTE: assert property (@(posedge clk) disable iff (rst)
    !routingOverride_reg[`EQR_OVERRIDE_BIT] |=>
    (firstOutputMuxSel == secondOutputMuxSel && firstOutputMuxSel[1:0] == $past(firstMuxCtrl_reg[3:2])))
    else $error("common routing mismatch");

  AST_OWN_ROUTE: assert property (@(posedge clk) disable iff (rst)
    routingOverride_reg[`EQR_OVERRIDE_BIT] |=>
    (firstOutputMuxSel == $past(firstMuxCtrl_reg[7:5]) && secondOutputMuxSel == $past(secondMuxCtrl_reg[7:5])))
    else $error("per-output routing mismatch");

  AST_CLOSED_PAGE_IGNORED: assert property (@(posedge clk) disable iff (rst)
    (regWrite && !pageOpen && !pageResetPulse_reg) |=>
    $stable(manualStageBoost_reg) && $stable(eqModeCtrl_reg) && $stable(spare_reg[2]))
    else $error("write took effect with page closed");

  AST_SPARE_STORES: assert property (@(posedge clk) disable iff (rst)
    (wrHit && regAddr == 8'h05) |=> spare_reg[1] == $past(regWdata))
    else $error("spare location did not store write");
endmodule

//--- tb/eqr_page_regs_test.sv
// Self-checking bench for the equalizer/retimer register page
`timescale 1ns/100ps
module eqr_page_regs_test;
  import eqr_pkg::*;
  logic clk;
  logic rst;
  eqr_page_t pageSelect;
  logic regWrite;
  logic regRead;
  eqr_byte_t regAddr;
  eqr_byte_t regWdata;
  eqr_byte_t regRdata;
  logic regRdValid;
  logic traceInputSignalLost;
  eqr_byte_t recoveryStatusIn;
  eqr_byte_t adaptiveBoost;
  eqr_byte_t appliedBoost;
  eqr_mux_sel_t firstOutputMuxSel;
  eqr_mux_sel_t secondOutputMuxSel;
  int nMismatch;
  int nChecks;

  eqr_page_regs uut (.clk(clk), .rst(rst), .pageSelect(pageSelect), .regWrite(regWrite), .regRead(regRead),
    .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata), .regRdValid(regRdValid),
    .traceInputSignalLost(traceInputSignalLost), .recoveryStatusIn(recoveryStatusIn),
    .adaptiveBoost(adaptiveBoost), .appliedBoost(appliedBoost), .firstOutputMuxSel(firstOutputMuxSel),
    .secondOutputMuxSel(secondOutputMuxSel));

  // Free-running 125 MHz management clock
  always #4 clk = ~clk;

  // Compare one value and count it
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    nChecks++;
    if (got !== exp) begin
      nMismatch++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Wait n edges; every task starts and ends 1 ns after an edge
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // One-cycle write strobe, then an idle edge so back-to-back calls never retoggle the strobe
  task automatic wr(input eqr_byte_t a, input eqr_byte_t d);
    regWrite = 1'b1;
    regAddr = a;
    regWdata = d;
    cyc(1);
    regWrite = 1'b0;
    cyc(1);
  endtask

  // Read strobe, answer looked at in the cycle it stands
  task automatic rd(input eqr_byte_t a, input eqr_byte_t exp, input string name);
    regRead = 1'b1;
    regAddr = a;
    cyc(1);
    regRead = 1'b0;
    chk({name, " valid"}, 8'h01, {7'h00, regRdValid});
    chk(name, exp, regRdata);
    cyc(1);
    chk({name, " validEnd"}, 8'h00, {7'h00, regRdValid});
  endtask

  // Defaults of the page reset, recovery status, boost and override registers, spares included
  task automatic test_defaults;
    rd(8'h00, 8'h00, "pageReset");
    rd(8'h02, 8'h41, "recoveryStatus");
    rd(8'h03, 8'h80, "manualBoost");
    for (int a = 4; a <= 8; a++) rd(a[7:0], 8'h00, "spare");
    rd(8'h09, 8'h00, "override");
  endtask

  // Loss flag follows the pin after the synchroniser
  task automatic test_los;
    traceInputSignalLost = 1'b0;
    cyc(3);
    rd(8'h01, 8'h01, "losPresent");
    traceInputSignalLost = 1'b1;
    cyc(3);
    rd(8'h01, 8'h03, "losLost");
    recoveryStatusIn = 8'h5a;
    cyc(4);
    rd(8'h02, 8'h5a, "recoveryLive");
    wr(8'h02, 8'h00);
    rd(8'h02, 8'h5a, "recoveryRo");
  endtask

  // Manual boost applied only with the enable bit set
  task automatic test_boost;
    wr(8'h03, 8'h1b);
    rd(8'h03, 8'h1b, "manualBoostRw");
    adaptiveBoost = 8'h3c;
    cyc(2);
    chk("appliedAdaptive", 8'h3c, appliedBoost);
    rd(8'h52, 8'h3c, "readbackAdaptive");
    wr(8'h2d, 8'h08);
    cyc(1);
    chk("appliedManual", 8'h1b, appliedBoost);
    rd(8'h52, 8'h1b, "readbackManual");
    wr(8'h2d, 8'h00);
    cyc(1);
    chk("appliedBack", 8'h3c, appliedBoost);
  endtask

  // Common routing, then per-output routing
  task automatic test_mux;
    wr(8'h1c, 8'had);
    wr(8'h1e, 8'hc2);
    cyc(1);
    chk("firstCommon", 8'h03, {5'h00, firstOutputMuxSel});
    chk("secondCommon", 8'h03, {5'h00, secondOutputMuxSel});
    wr(8'h09, 8'h20);
    cyc(1);
    chk("firstOwn", 8'h05, {5'h00, firstOutputMuxSel});
    chk("secondOwn", 8'h06, {5'h00, secondOutputMuxSel});
  endtask

  // Page reset restores defaults; write right behind it is dropped
  task automatic test_page_reset;
    wr(8'h05, 8'h77);
    // Strobe held up over two edges: the second write lands in the strobe cycle
    regWrite = 1'b1;
    regAddr = 8'h00;
    regWdata = 8'h04;
    cyc(1);
    regAddr = 8'h03;
    regWdata = 8'h11;
    cyc(1);
    regWrite = 1'b0;
    cyc(1);
    rd(8'h03, 8'h80, "boostAfterReset");
    rd(8'h09, 8'h00, "overrideAfterReset");
    rd(8'h05, 8'h00, "spareAfterReset");
    rd(8'h00, 8'h00, "selfClear");
    chk("firstAfterReset", 8'h00, {5'h00, firstOutputMuxSel});
    // Software re-initialises before relying on the page
    wr(8'h03, 8'h80);
  endtask

  // Closed page ignores writes and reads zero
  task automatic test_closed_page;
    wr(8'h06, 8'h5c);
    pageSelect = 3'h5;
    wr(8'h06, 8'ha3);
    rd(8'h06, 8'h00, "closedRead");
    pageSelect = 3'h4;
    rd(8'h06, 8'h5c, "closedWrite");
    rd(8'h40, 8'h00, "unmapped");
  endtask

  // Single end of run
  task automatic results;
    $display("Checks %0d mismatches %0d", nChecks, nMismatch);
    if (nMismatch == 0 && nChecks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Cuts a hang short
  initial begin
    #20000;
    nMismatch++;
    results();
  end

  // Main sequence
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    pageSelect = 3'h4;
    regWrite = 1'b0;
    regRead = 1'b0;
    regAddr = 8'h00;
    regWdata = 8'h00;
    traceInputSignalLost = 1'b1;
    recoveryStatusIn = 8'h41;
    adaptiveBoost = 8'h00;
    nMismatch = 0;
    nChecks = 0;
    cyc(4);
    rst = 1'b0;
    test_defaults();
    test_los();
    test_boost();
    test_mux();
    test_page_reset();
    test_closed_page();
    results();
  end
endmodule
